// file: testbench.sv
// testbench: self-checking run of the watchdog control block
`timescale 1ns/1ps
`define CK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; $display("BAD %s exp %h got %h", nm, e, s); end end
module testbench;
	localparam int TD = 2;
	localparam logic [3:0] A0 = wdtc_pkg::CTRL_STATUS_OFS;
	localparam logic [3:0] A4 = wdtc_pkg::RESET_CAUSE_OFS;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0;
	logic [3:0] s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic wd_always_on_fuse = 1'h1, svc = 1'h0, gie = 1'h1, kick = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp, ev;
	logic [31:0] s_axi_rdata, rdat;
	logic global_int_enable, wd_vector_ack, wd_restart, wd_irq_req, wd_sys_reset;
	logic [3:0] c;
	int fails = 0, n_checks = 0, seed = 67, te;
	// short tick divider keeps time-outs within a few thousand cycles
	wdtc_top #(.TICK_DIV(TD)) i_wdtc_top (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wd_always_on_fuse,
		.global_int_enable, .wd_vector_ack, .wd_restart, .wd_irq_req, .wd_sys_reset);
	wdtc_core_model i_core (.aclk, .aresetn, .svc, .gie, .kick, .wd_irq_req,
		.global_int_enable, .wd_vector_ack, .wd_restart);
	// free-running bus clock
	always #10 aclk = ~aclk;
	function automatic int per(logic [3:0] k);
		return (2048 << k) * TD;
	endfunction : per
	function automatic logic [7:0] fld(logic [3:0] k, logic ie, logic re);
		return {1'h0, ie, k[3], 1'h0, re, k[2:0]};
	endfunction : fld
	// write: both beats offered, each dropped when taken
	task automatic wr(logic [3:0] a, logic [7:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		// always pass one edge: a stale bvalid from the last write still shows here
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		// bready stays up, so a following write does not toggle it in one step
		resp = s_axi_bresp;
	endtask : wr
	task automatic rd(logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		// always pass one edge: a stale rvalid from the last read still shows here
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
	endtask : rd
	task automatic chk(logic [3:0] a, logic [7:0] e, logic [1:0] r = wdtc_pkg::RESP_OKAY);
		rd(a);
		`CK("rdata", {24'h00_0000, e}, rdat)
		`CK("rresp", r, resp)
	endtask : chk
	// open the change window, then write within it
	task automatic unl(logic [7:0] d);
		wr(A0, 8'h18);
		wr(A0, d);
	endtask : unl
	// wait for a masked event, bounded
	task automatic wt(int n, logic [1:0] m);
		ev = 2'h0;
		te = 0;
		while (te < n && (ev & m) == 2'h0) begin
			@(posedge aclk);
			ev = {wd_sys_reset === 1'h1, wd_irq_req === 1'h1};
			te++;
		end
	endtask : wt
	task automatic go();
		kick <= 1'h1;
		@(posedge aclk);
		kick <= 1'h0;
	endtask : go
	task automatic drain();
		for (int k = 0; k < 30 && wd_irq_req !== 1'h0; k++) @(posedge aclk);
		`CK("irq_low", 1'h0, wd_irq_req)
	endtask : drain
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out
	// watchdog on the whole run
	initial begin
		#(90000 * 20);
		fails++;
		close_out();
	end
	// main sequence
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		c = $random(seed) & 1;
		chk(A0, 8'h00);
		chk(A4, 8'h00);
		chk(4'h8, 8'h00, wdtc_pkg::RESP_SLVERR);
		wr(4'h8, $random(seed));
		`CK("bresp", wdtc_pkg::RESP_SLVERR, resp)
		wt(per(0) + 50, 2'h3);
		`CK("stopped", 2'h0, ev)
		wr(A0, 8'h21);
		chk(A0, 8'h00);
		unl(fld(c, 1, 0));
		chk(A0, fld(c, 1, 0));
		svc <= 1'h1;
		go();
		wt(2 * per(c), 2'h3);
		`CK("irq", 2'h1, ev)
		`CK("tout", 1'h1, te > per(c) - 30 && te < per(c) + 30)
		drain();
		wt(2 * per(c), 2'h3);
		`CK("irq2", 2'h1, ev)
		`CK("period", 1'h1, te > per(c) - 30 && te < per(c) + 30)
		drain();
		wr(A0, 8'h18);
		repeat (6) @(posedge aclk);
		wr(A0, fld(c, 1, 0));
		chk(A0, fld(c, 1, 1));
		go();
		wt(2 * per(c), 2'h3);
		`CK("comb", 2'h1, ev)
		drain();
		chk(A0, fld(c, 0, 1));
		wt(2 * per(c), 2'h2);
		`CK("rst", 2'h2, ev)
		chk(A4, 8'h08);
		svc <= 1'h0;
		wr(A0, fld(c, 1, 1));
		go();
		wt(2 * per(c), 2'h3);
		`CK("comb2", 2'h1, ev)
		wr(A0, fld(c, 1, 1));
		chk(A0, fld(c, 1, 1) | 8'h80);
		wt(2 * per(c), 2'h2);
		`CK("rst2", 2'h3, ev)
		wr(A0, fld(c, 0, 1) | 8'h80);
		unl(fld(c, 0, 0));
		chk(A0, fld(c, 0, 1));
		wr(A4, 8'h00);
		chk(A4, 8'h00);
		unl(8'h00);
		chk(A0, 8'h00);
		gie <= 1'h0;
		wr(A0, 8'h40);
		wt(per(0) + 50, 2'h3);
		`CK("masked", 2'h0, ev)
		chk(A0, 8'hc0);
		gie <= 1'h1;
		wt(8, 2'h1);
		`CK("unmasked", 2'h1, ev)
		wr(A0, 8'hc0);
		chk(A0, 8'h40);
		wd_always_on_fuse <= 1'h0;
		repeat (8) @(posedge aclk);
		chk(A0, 8'h08);
		go();
		wt(2 * per(0), 2'h3);
		`CK("fuse", 2'h2, ev)
		close_out();
	end
endmodule : testbench

// file: wdtc_core_model.sv
// wdtc_core_model: processor core side that takes the watchdog vector
`timescale 1ns/1ps
module wdtc_core_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic svc,
	input wire logic gie,
	input wire logic kick,
	input wire logic wd_irq_req,
	output logic global_int_enable,
	output logic wd_vector_ack,
	output logic wd_restart
);
	logic busy;
	logic slow;
	logic [3:0] cnt;
	// vector taken after a short or long latency, alternating
	// enable is never re-armed in the service itself
	always @(posedge aclk) begin
		global_int_enable <= gie;
		wd_restart <= kick;
		wd_vector_ack <= 1'h0;
		if (!aresetn) begin
			busy <= 1'h0;
			slow <= 1'h0;
			cnt <= 4'h0;
		end else if (!busy && svc && wd_irq_req) begin
			busy <= 1'h1;
			slow <= !slow;
			cnt <= slow ? 4'h6 : 4'h1;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
			wd_vector_ack <= (cnt == 4'h1);
		end else if (!wd_irq_req) begin
			busy <= 1'h0;
		end
	end
endmodule : wdtc_core_model

// file: wdtc_pkg.sv
// wdtc_pkg: constants and types shared by the watchdog control block
package wdtc_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses on the control bus)
	// ---------------------------------------------------------------
	localparam logic [3:0] CTRL_STATUS_OFS = 4'h0;
	localparam logic [3:0] RESET_CAUSE_OFS = 4'h4;

	// ---------------------------------------------------------------
	// control/status field positions
	// ---------------------------------------------------------------
	localparam int INT_FLAG_BIT = 7;
	localparam int INT_ENABLE_BIT = 6;
	localparam int PRESCALE_HI_BIT = 5;
	localparam int CHANGE_ENABLE_BIT = 4;
	localparam int RESET_ENABLE_BIT = 3;
	localparam int PRESCALE_LO_MSB = 2;
	// reset-cause field position
	localparam int RESET_FLAG_BIT = 3;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [3:0] PRESCALE_RST = 4'h0;
	localparam logic [2:0] CE_CNT_RST = 3'h0;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int OSC_HZ = 128_000;
	// oscillator tick divider, rounded down
	localparam int TICK_DIV = CLK_HZ / OSC_HZ;
	// change enable lives this many clock cycles
	localparam int CE_CYCLES = 4;
	// shortest time-out in oscillator cycles, doubled per code
	localparam int BASE_TIMEOUT = 2048;
	// highest code that is not reserved
	localparam logic [3:0] PRESCALE_MAX = 4'h9;

	// ---------------------------------------------------------------
	// bus answers
	// ---------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : wdtc_pkg

// file: wdtc_top.sv
// wdtc_top: watchdog timer with control/status register on AXI4-Lite
`timescale 1ns/1ps

module wdtc_top #(
	parameter int ADDR_W = 4,
	parameter int TICK_DIV = wdtc_pkg::TICK_DIV,
	parameter int CNT_W = 20
) (
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// fuse pin, 1 = unprogrammed, 0 = programmed
	input wire logic wd_always_on_fuse,
	// processor core side, same clock
	input wire logic global_int_enable,
	input wire logic wd_vector_ack,
	input wire logic wd_restart,
	// requests to interrupt and reset logic
	output logic wd_irq_req,
	output logic wd_sys_reset
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic fuse_meta;
		logic fuse_sync;
		logic [15:0] div_cnt;
		logic tick;
		logic [CNT_W-1:0] wd_cnt;
		logic wd_int_flag;
		logic wd_int_enable;
		logic wd_reset_enable;
		logic [3:0] wd_prescale_select;
		logic wd_change_enable;
		logic [2:0] ce_cnt;
		logic wd_reset_flag;
		logic aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic irq;
		logic sys_reset;
	} wdtc_state_t;

	localparam logic [2:0] CE_LOAD = 3'(wdtc_pkg::CE_CYCLES);
	localparam logic [15:0] DIV_LAST = 16'(TICK_DIV - 1);
	localparam logic [CNT_W:0] BASE_CNT = (CNT_W+1)'(wdtc_pkg::BASE_TIMEOUT);

	wdtc_state_t s_r;
	wdtc_state_t s_nxt;

	// reset image: fuse assumed unprogrammed until sampled
	function automatic wdtc_state_t wdtc_reset_state();
		wdtc_state_t r;
		r = '0;
		r.fuse_meta = 1'b1;
		r.fuse_sync = 1'b1;
		r.wd_prescale_select = wdtc_pkg::PRESCALE_RST;
		r.ce_cnt = wdtc_pkg::CE_CNT_RST;
		r.awready = 1'b1;
		r.wready = 1'b1;
		r.arready = 1'b1;
		return r;
	endfunction : wdtc_reset_state

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		logic fuse_prog;
		logic running;
		logic timeout;
		logic do_write;
		logic wr_ctrl;
		logic wr_cause;
		logic [3:0] ps_eff;
		logic [CNT_W:0] limit;
		logic [7:0] wb;
		logic [3:0] ps_new;
		fuse_prog = 1'b0;
		running = 1'b0;
		timeout = 1'b0;
		do_write = 1'b0;
		wr_ctrl = 1'b0;
		wr_cause = 1'b0;
		ps_eff = 4'h0;
		limit = '0;
		wb = 8'h00;
		ps_new = 4'h0;
		s_nxt = s_r;

		// two-flop synchroniser for the fuse pin
		s_nxt.fuse_meta = wd_always_on_fuse;
		s_nxt.fuse_sync = s_r.fuse_meta;
		fuse_prog = ~s_r.fuse_sync;

		// oscillator-rate tick from the system clock
		s_nxt.tick = 1'b0;
		if (s_r.div_cnt == DIV_LAST) begin
			s_nxt.div_cnt = 16'h0000;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.div_cnt = s_r.div_cnt + 16'h0001;
		end

		// reserved codes behave as the longest period
		ps_eff = (s_r.wd_prescale_select > wdtc_pkg::PRESCALE_MAX) ?
			wdtc_pkg::PRESCALE_MAX : s_r.wd_prescale_select;
		limit = BASE_CNT << ps_eff;

		// stopped only when fuse unprogrammed and both enables clear
		running = fuse_prog | s_r.wd_reset_enable | s_r.wd_int_enable;

		// time-out counter
		if (wd_restart || !running) begin
			s_nxt.wd_cnt = '0;
		end else if (s_r.tick) begin
			if ({1'b0, s_r.wd_cnt} == limit - (CNT_W+1)'(1)) begin
				timeout = 1'b1;
				s_nxt.wd_cnt = '0;
			end else begin
				s_nxt.wd_cnt = s_r.wd_cnt + CNT_W'(1);
			end
		end

		// change enable countdown
		if (s_r.ce_cnt != 3'h0) begin
			s_nxt.ce_cnt = s_r.ce_cnt - 3'h1;
			if (s_r.ce_cnt == 3'h1) begin
				s_nxt.wd_change_enable = 1'b0;
			end
		end

		// hardware clears on interrupt vector execution
		if (wd_vector_ack) begin
			s_nxt.wd_int_flag = 1'b0;
			if (s_r.wd_reset_enable) begin
				s_nxt.wd_int_enable = 1'b0;
			end
		end

		// ----- AXI4-Lite write channel -----
		if (s_r.awready && s_axi_awvalid) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_r.wready && s_axi_wvalid) begin
			s_nxt.w_got = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		do_write = s_r.aw_got && s_r.w_got && !s_r.bvalid;
		if (do_write) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			if (s_r.aw_addr == ADDR_W'(wdtc_pkg::CTRL_STATUS_OFS)) begin
				wr_ctrl = s_r.w_strb[0];
				s_nxt.bresp = wdtc_pkg::RESP_OKAY;
			end else if (s_r.aw_addr == ADDR_W'(wdtc_pkg::RESET_CAUSE_OFS)) begin
				wr_cause = s_r.w_strb[0];
				s_nxt.bresp = wdtc_pkg::RESP_OKAY;
			end else begin
				s_nxt.bresp = wdtc_pkg::RESP_SLVERR;
			end
		end
		wb = s_r.w_data[7:0];

		// control/status write effects
		if (wr_ctrl) begin
			if (wb[wdtc_pkg::INT_FLAG_BIT]) begin
				s_nxt.wd_int_flag = 1'b0;
			end
			s_nxt.wd_int_enable = wb[wdtc_pkg::INT_ENABLE_BIT];
			// prescaler only moves while change enable is live; reset enable can be set any time but is cleared only then
			ps_new = {wb[wdtc_pkg::PRESCALE_HI_BIT], wb[wdtc_pkg::PRESCALE_LO_MSB:0]};
			if (s_r.wd_change_enable) begin
				s_nxt.wd_prescale_select = ps_new;
			end
			if (wb[wdtc_pkg::RESET_ENABLE_BIT]) begin
				s_nxt.wd_reset_enable = 1'b1;
			end else if (s_r.wd_change_enable) begin
				s_nxt.wd_reset_enable = 1'b0;
			end
			if (wb[wdtc_pkg::CHANGE_ENABLE_BIT]) begin
				s_nxt.wd_change_enable = 1'b1;
				s_nxt.ce_cnt = CE_LOAD;
			end else begin
				// the second write of the sequence closes the window
				s_nxt.wd_change_enable = 1'b0;
				s_nxt.ce_cnt = 3'h0;
			end
		end

		// reset-cause write: zero clears the watchdog flag
		if (wr_cause && !wb[wdtc_pkg::RESET_FLAG_BIT]) begin
			s_nxt.wd_reset_flag = 1'b0;
		end

		// time-out action; events here win over clears above
		s_nxt.sys_reset = 1'b0;
		if (timeout) begin
			if (fuse_prog || (s_r.wd_reset_enable && !s_r.wd_int_enable)) begin
				s_nxt.sys_reset = 1'b1;
			end else if (s_r.wd_int_enable && !s_r.wd_reset_enable) begin
				s_nxt.wd_int_flag = 1'b1;
			end else if (s_r.wd_int_flag) begin
				s_nxt.sys_reset = 1'b1;
			end else begin
				s_nxt.wd_int_flag = 1'b1;
			end
		end
		if (s_nxt.sys_reset) begin
			s_nxt.wd_reset_flag = 1'b1;
		end

		// forcing of the enables by flag and fuse
		if (s_nxt.wd_reset_flag) begin
			s_nxt.wd_reset_enable = 1'b1;
		end
		if (fuse_prog) begin
			s_nxt.wd_reset_enable = 1'b1;
			s_nxt.wd_int_enable = 1'b0;
		end

		// interrupt request to the core
		s_nxt.irq = s_nxt.wd_int_flag & s_nxt.wd_int_enable & global_int_enable;

		// channel readies: one write outstanding at a time
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;

		// ----- AXI4-Lite read channel -----
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_r.arready && s_axi_arvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = 32'h0000_0000;
			s_nxt.rresp = wdtc_pkg::RESP_OKAY;
			if (s_axi_araddr == ADDR_W'(wdtc_pkg::CTRL_STATUS_OFS)) begin
				s_nxt.rdata[7:0] = {s_r.wd_int_flag, s_r.wd_int_enable,
					s_r.wd_prescale_select[3], s_r.wd_change_enable,
					s_r.wd_reset_enable, s_r.wd_prescale_select[2:0]};
			end else if (s_axi_araddr == ADDR_W'(wdtc_pkg::RESET_CAUSE_OFS)) begin
				s_nxt.rdata[wdtc_pkg::RESET_FLAG_BIT] = s_r.wd_reset_flag;
			end else begin
				s_nxt.rresp = wdtc_pkg::RESP_SLVERR;
			end
		end
		s_nxt.arready = !s_nxt.rvalid;
	end

	// ---------------------------------------------------------------
	// state register, synchronous active-low reset
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= wdtc_reset_state();
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state flops
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign wd_irq_req = s_r.irq;
	assign wd_sys_reset = s_r.sys_reset;

endmodule : wdtc_top

// file: wdtc_top_checker.sv
// wdtc_top_checker: port assertions for the watchdog control block
`timescale 1ns/1ps
module wdtc_top_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic wd_always_on_fuse,
	input wire logic global_int_enable,
	input wire logic wd_vector_ack,
	input wire logic wd_irq_req,
	input wire logic wd_sys_reset
);
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// both write beats taken on one edge
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// fuse seen programmed long enough to pass the synchroniser
	sequence s_fuse_held;
		!wd_always_on_fuse [*8];
	endsequence
	property p_wr_resp;
		s_wr_taken |-> ##2 s_axi_bvalid;
	endproperty
	property p_b_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_rd_resp;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	property p_rd_upper;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
	endproperty
	property p_irq_gie;
		wd_irq_req |-> $past(global_int_enable);
	endproperty
	property p_rst_pulse;
		wd_sys_reset |=> !wd_sys_reset;
	endproperty
	property p_fuse;
		s_fuse_held |-> !wd_irq_req;
	endproperty
	property p_ack_clr;
		wd_vector_ack |-> ##2 !wd_irq_req;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	a_b_block: assert property (p_b_block) else $error("write taken while answering");
	a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
	a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
	a_irq_gie: assert property (p_irq_gie) else $error("irq without global enable");
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
	a_fuse: assert property (p_fuse) else $error("irq with fuse programmed");
	a_ack_clr: assert property (p_ack_clr) else $error("irq kept after vector");
endmodule : wdtc_top_checker

bind wdtc_top wdtc_top_checker i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rdata, .wd_always_on_fuse, .global_int_enable, .wd_vector_ack,
	.wd_irq_req, .wd_sys_reset);
